//--- rtl/bct_top.sv
// Bridge control register, upper half: master timeouts, secondary reset,
// master abort handling and system error signalling.
// Assumes configuration cycles arrive already decoded on the PCI clock and
// that the queues drive head and repeat indications on the same clock.
`default_nettype none
`include "bct_cfg.svh"

module bct_top
    import bct_pkg::*;
#(
    parameter int LONG_CYCLES = `BCT_TMO_LONG_CYC,
    parameter int SHORT_CYCLES = `BCT_TMO_SHORT_CYC
) (
    // Clock and bridge reset
    input wire logic clk_i,
    input wire logic rstn_i,

    // Configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [3:0] primary_byte_enables_n_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,

    // Command register system error enable
    input wire logic cmd_system_error_forward_enable_i,

    // Delayed completion queues, index 0 primary, 1 secondary
    input wire logic [`BCT_NUM_BUS-1:0] dc_head_i,
    input wire logic [`BCT_NUM_BUS-1:0] dc_repeat_i,
    output logic [`BCT_NUM_BUS-1:0] dc_discard_o,

    // Master abort reports from the bridge's own master
    input wire logic ma_event_i,
    input wire logic ma_posted_i,
    input wire logic ma_read_i,
    output logic ma_normal_done_o,
    output logic ma_target_abort_o,
    output logic [31:0] ma_rdata_o,

    // Secondary bus controls
    output logic secondary_reset_n_o,
    output logic sec_logic_reset_n_o,
    output logic sec_fast_b2b_o,

    // System error pins, open drain
    input wire logic secondary_system_error_in_n_i,
    output logic primary_system_error_out_o,
    output logic primary_system_error_out_oe_o
);
    // Register fields
    logic tmo_system_error_forward_enable_q;
    logic tmo_status_q;
    logic tmo_status_d;
    logic sec_tmo_sel_q;
    logic pri_tmo_sel_q;
    logic sec_reset_q;
    logic ma_mode_q;
    logic [3:0] low_bits_q;
    logic [31:0] rdata_d;

    // Access decode
    wire logic [5:0] ofs_w = 6'(`BCT_REG_OFS >> 2);
    wire logic sel_w = (cfg_addr_i[7:2] == ofs_w);
    wire logic wr_w = cfg_wr_i && sel_w;
    wire logic rd_w = cfg_rd_i && sel_w;
    wire logic [3:0] lane_w = ~primary_byte_enables_n_i;
    wire logic [31:0] lane_mask_w = {
        {8{lane_w[3]}}, {8{lane_w[2]}}, {8{lane_w[1]}}, {8{lane_w[0]}}
    };
    // Only the writable fields can change; fixed fields ignore data
    wire logic [31:0] wmask_w = lane_mask_w & `BCT_WR_MASK;
    wire logic [31:0] wbits_w = cfg_wdata_i & wmask_w;
    wire logic [31:0] upd_w = {32{wr_w}} & wmask_w;
    wire logic w1c_w = wr_w && lane_w[3]
        && cfg_wdata_i[`BCT_BIT_TMO_STATUS];

    wire logic [31:0] reg_val_w = {
        4'h0,
        tmo_system_error_forward_enable_q,
        tmo_status_q,
        sec_tmo_sel_q,
        pri_tmo_sel_q,
        1'b0,
        sec_reset_q,
        ma_mode_q,
        1'b0,
        low_bits_q,
        16'h0000
    };

    // Timers
    wire logic [`BCT_NUM_BUS-1:0] short_w = {sec_tmo_sel_q, pri_tmo_sel_q};
    wire logic [`BCT_NUM_BUS-1:0] clr_w = {sec_reset_q, 1'b0};
    logic [`BCT_NUM_BUS-1:0] expire_w;

    genvar gi;
    generate
        for (gi = 0; gi < `BCT_NUM_BUS; gi++) begin : g_tmr
            bct_timer #(
                .LONG_CYC(bct_cnt_t'(LONG_CYCLES - 1)),
                .SHORT_CYC(bct_cnt_t'(SHORT_CYCLES - 1))
            ) u_tmr (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .clr_i(clr_w[gi]),
                .head_i(dc_head_i[gi]),
                .repeat_i(dc_repeat_i[gi]),
                .short_i(short_w[gi]),
                .expire_o(expire_w[gi])
            );
        end
    endgenerate

    wire logic tmo_any_w = |expire_w;

    // Secondary SERR pin synchroniser, first stage read only by second
    logic sserr_s1_q;
    logic sserr_s2_q;
    logic sserr_s3_q;
    logic sserr_seen_q;
    wire logic sserr_agree_w = (sserr_s2_q == sserr_s3_q);

    // System error sources
    wire logic tmo_serr_w = tmo_any_w && tmo_system_error_forward_enable_q
        && cmd_system_error_forward_enable_i;
    wire logic ma_post_w = ma_event_i && ma_posted_i;
    wire logic ma_dly_w = ma_event_i && !ma_posted_i;
    wire logic ma_serr_w = ma_post_w && ma_mode_q && cmd_system_error_forward_enable_i;
    wire logic fwd_serr_w = sserr_seen_q && low_bits_q[1]
        && cmd_system_error_forward_enable_i;
    wire logic serr_w = tmo_serr_w || ma_serr_w || fwd_serr_w;

    // Set wins over the software clear
    always_comb begin
        tmo_status_d = tmo_status_q;
        if (w1c_w) begin
            tmo_status_d = 1'b0;
        end
        if (tmo_any_w) begin
            tmo_status_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = `BCT_ZERO32;
        if (rd_w) begin
            rdata_d = reg_val_w;
        end
    end

    // Register storage; secondary reset does not touch it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tmo_system_error_forward_enable_q <= 1'b0;
            sec_tmo_sel_q <= 1'b0;
            pri_tmo_sel_q <= 1'b0;
            sec_reset_q <= 1'b0;
            ma_mode_q <= 1'b0;
            low_bits_q <= 4'h0;
            tmo_status_q <= 1'b0;
        end else begin
            if (upd_w[`BCT_BIT_TMO_SYSTEM_ERROR_FORWARD_ENABLE]) begin
                tmo_system_error_forward_enable_q <= wbits_w[`BCT_BIT_TMO_SYSTEM_ERROR_FORWARD_ENABLE];
            end
            if (upd_w[`BCT_BIT_SEC_TMO_SEL]) begin
                sec_tmo_sel_q <= wbits_w[`BCT_BIT_SEC_TMO_SEL];
            end
            if (upd_w[`BCT_BIT_PRI_TMO_SEL]) begin
                pri_tmo_sel_q <= wbits_w[`BCT_BIT_PRI_TMO_SEL];
            end
            if (upd_w[`BCT_BIT_SEC_RESET]) begin
                sec_reset_q <= wbits_w[`BCT_BIT_SEC_RESET];
            end
            if (upd_w[`BCT_BIT_MA_MODE]) begin
                ma_mode_q <= wbits_w[`BCT_BIT_MA_MODE];
            end
            if (wr_w && lane_w[2]) begin
                low_bits_q <= wbits_w[19:16];
            end
            tmo_status_q <= tmo_status_d;
        end
    end

    // Configuration read path
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_rdata_o <= `BCT_ZERO32;
            cfg_ack_o <= 1'b0;
        end else begin
            cfg_rdata_o <= rdata_d;
            cfg_ack_o <= cfg_wr_i || cfg_rd_i;
        end
    end

    // Secondary bus reset follows the control bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            secondary_reset_n_o <= 1'b1;
            sec_logic_reset_n_o <= 1'b1;
            sec_fast_b2b_o <= 1'b0;
        end else begin
            secondary_reset_n_o <= !sec_reset_q;
            sec_logic_reset_n_o <= !sec_reset_q;
            sec_fast_b2b_o <= 1'b0;
        end
    end

    // Discard strobes to the queues
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dc_discard_o <= '0;
        end else begin
            dc_discard_o <= expire_w & ~clr_w;
        end
    end

    // Master abort completions on the initiator bus
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ma_normal_done_o <= 1'b0;
            ma_target_abort_o <= 1'b0;
            ma_rdata_o <= `BCT_ZERO32;
        end else begin
            ma_normal_done_o <= ma_dly_w && !ma_mode_q;
            ma_target_abort_o <= ma_dly_w && ma_mode_q;
            if (ma_dly_w && !ma_mode_q && ma_read_i) begin
                ma_rdata_o <= `BCT_ALL_ONES;
            end else begin
                ma_rdata_o <= `BCT_ZERO32;
            end
        end
    end

    // Pin input: a change counts once second and third stages agree
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sserr_s1_q <= 1'b1;
            sserr_s2_q <= 1'b1;
            sserr_s3_q <= 1'b1;
            sserr_seen_q <= 1'b0;
        end else begin
            sserr_s1_q <= secondary_system_error_in_n_i;
            sserr_s2_q <= sserr_s1_q;
            sserr_s3_q <= sserr_s2_q;
            if (sserr_agree_w) begin
                sserr_seen_q <= !sserr_s2_q;
            end
        end
    end

    // Open drain: only ever pulls low, enable marks the drive
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            primary_system_error_out_o <= 1'b0;
            primary_system_error_out_oe_o <= 1'b0;
        end else begin
            primary_system_error_out_o <= 1'b0;
            primary_system_error_out_oe_o <= serr_w;
        end
    end
endmodule : bct_top

`default_nettype wire

//--- rtl/bct_cfg.svh
// Constants for the bridge control timeout and abort block.
// Assumes inclusion by bare name from every rtl file that needs them.
//
// Overview of operation
// - Timeout and command SERR enables: timeout discard drives primary SERR.
// - Timeout error enable clear: a timeout never drives primary SERR.
// - Timeout discard sets the status bit; software writes one to clear.
// - Secondary timer runs from head; expiry without repeat discards.
// - Secondary select bit: zero gives 2^15 clocks, one gives 2^10.
// - Primary timer runs from head, 2^15 or 2^10 clocks, then discards.
// - Secondary fast back-to-back bit reads zero; never generated.
// - Secondary bus reset bit drives the secondary reset output directly.
// - Secondary reset clears secondary logic; primary and registers kept.
// - Abort mode zero: delayed complete normally, reads return ones.
// - Abort mode one: delayed get target abort; posted raise SERR if command SERR enable set.
// - Bits 31:28 and bit 20 are read-only zero.
// - Bridge reset sets every field of the register to zero.
// - Forward and SERR enables: secondary SERR seen drives primary SERR.
`ifndef BCT_CFG_SVH
`define BCT_CFG_SVH

`define BCT_REG_OFS 8'h3C
`define BCT_RESET_VAL 32'h0000_0000
`define BCT_WR_MASK 32'h0B6F_0000
`define BCT_ALL_ONES 32'hFFFF_FFFF
`define BCT_ZERO32 32'h0000_0000

`define BCT_BIT_TMO_SYSTEM_ERROR_FORWARD_ENABLE 27
`define BCT_BIT_TMO_STATUS 26
`define BCT_BIT_SEC_TMO_SEL 25
`define BCT_BIT_PRI_TMO_SEL 24
`define BCT_BIT_SEC_FB2B 23
`define BCT_BIT_SEC_RESET 22
`define BCT_BIT_MA_MODE 21
`define BCT_BIT_SERR_FWD_EN 17

`define BCT_TMO_LONG_CYC 32768
`define BCT_TMO_SHORT_CYC 1024
`define BCT_CNT_W 16
`define BCT_NUM_BUS 2
`define BCT_BUS_PRI 0
`define BCT_BUS_SEC 1

`endif

//--- rtl/bct_pkg.sv
// Types shared by the bridge control timeout and abort block.
// Assumes bct_cfg.svh holds the numeric constants.
`default_nettype none
`include "bct_cfg.svh"

package bct_pkg;
    typedef logic [`BCT_CNT_W-1:0] bct_cnt_t;
    typedef enum logic [1:0] {
        BCT_T_IDLE,
        BCT_T_RUN,
        BCT_T_DONE
    } bct_tmr_e;
endpackage : bct_pkg

`default_nettype wire

//--- rtl/bct_timer.sv
// Master timeout counter for one bus.
// Assumes head_i stays high while the completion sits at the queue head.
`default_nettype none
`include "bct_cfg.svh"

module bct_timer
    import bct_pkg::*;
#(
    parameter bct_cnt_t LONG_CYC = bct_cnt_t'(`BCT_TMO_LONG_CYC - 1),
    parameter bct_cnt_t SHORT_CYC = bct_cnt_t'(`BCT_TMO_SHORT_CYC - 1)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clr_i,
    // Queue side
    input wire logic head_i,
    input wire logic repeat_i,
    input wire logic short_i,
    // Expiry pulse
    output logic expire_o
);
    bct_tmr_e state_q;
    bct_tmr_e state_d;
    bct_cnt_t cnt_q;
    bct_cnt_t cnt_d;
    logic expire_d;
    // LONG_CYC and SHORT_CYC hold the last count, one less than the length
    wire bct_cnt_t last_w = short_i ? SHORT_CYC : LONG_CYC;
    wire logic hit_w = (cnt_q == last_w);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        expire_d = 1'b0;
        case (state_q)
            BCT_T_IDLE: begin
                cnt_d = '0;
                if (head_i) begin
                    state_d = BCT_T_RUN;
                end
            end
            BCT_T_RUN: begin
                if (!head_i || repeat_i) begin
                    state_d = head_i ? BCT_T_DONE : BCT_T_IDLE;
                end else if (hit_w) begin
                    expire_d = 1'b1;
                    state_d = BCT_T_DONE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BCT_T_DONE: begin
                if (!head_i) begin
                    state_d = BCT_T_IDLE;
                end
            end
            default: begin
                state_d = BCT_T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= BCT_T_IDLE;
            cnt_q <= '0;
            expire_o <= 1'b0;
        end else if (clr_i) begin
            state_q <= BCT_T_IDLE;
            cnt_q <= '0;
            expire_o <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            expire_o <= expire_d;
        end
    end
endmodule : bct_timer

`default_nettype wire

//--- testbench/bct_monitor.sv
// Port checker for bct_top.
// Assumes it is bound into every bct_top instance.
`default_nettype none
module bct_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_ack_o,
    input wire logic [31:0] cfg_rdata_o,
    // Queues and aborts
    input wire logic [1:0] dc_head_i,
    input wire logic [1:0] dc_discard_o,
    input wire logic ma_event_i,
    input wire logic ma_posted_i,
    input wire logic ma_read_i,
    input wire logic ma_normal_done_o,
    input wire logic ma_target_abort_o,
    input wire logic [31:0] ma_rdata_o,
    // Secondary side
    input wire logic secondary_reset_n_o,
    input wire logic sec_logic_reset_n_o,
    input wire logic sec_fast_b2b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_dly_req; ma_event_i && !ma_posted_i; endsequence
    sequence s_one_ans; ma_normal_done_o ^ ma_target_abort_o; endsequence
    property p_ack; cfg_wr_i || cfg_rd_i |=> cfg_ack_o; endproperty
    property p_rsvd;
        cfg_ack_o |-> cfg_rdata_o[31:28] == 4'h0 && !cfg_rdata_o[20];
    endproperty
    property p_fb2b; !sec_fast_b2b_o && !(cfg_ack_o && cfg_rdata_o[23]);
    endproperty
    property p_dly; s_dly_req |=> s_one_ans; endproperty
    property p_ones; s_dly_req ##0 ma_read_i ##1 ma_normal_done_o
        |-> ma_rdata_o == 32'hFFFF_FFFF; endproperty
    property p_post; ma_event_i && ma_posted_i
        |=> !ma_normal_done_o && !ma_target_abort_o; endproperty
    property p_srst; secondary_reset_n_o == sec_logic_reset_n_o; endproperty
    property p_hold; !secondary_reset_n_o |-> !dc_discard_o[1]; endproperty
    property p_pdisc; dc_discard_o[0] |-> $past(dc_head_i[0], 2); endproperty
    property p_sdisc; dc_discard_o[1] |-> $past(dc_head_i[1], 2); endproperty
    a_ack: assert property (p_ack) else $error("config not acked");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    a_fb2b: assert property (p_fb2b) else $error("fast b2b seen");
    a_dly: assert property (p_dly) else $error("abort answer bad");
    a_ones: assert property (p_ones) else $error("read data not ones");
    a_post: assert property (p_post) else $error("posted answered");
    a_srst: assert property (p_srst) else $error("resets differ");
    a_hold: assert property (p_hold) else $error("discard in reset");
    a_pdisc: assert property (p_pdisc) else $error("pri discard idle");
    a_sdisc: assert property (p_sdisc) else $error("sec discard idle");
endmodule : bct_monitor
bind bct_top bct_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_ack_o(cfg_ack_o),
    .cfg_rdata_o(cfg_rdata_o), .dc_head_i(dc_head_i),
    .dc_discard_o(dc_discard_o), .ma_event_i(ma_event_i),
    .ma_posted_i(ma_posted_i), .ma_read_i(ma_read_i),
    .ma_normal_done_o(ma_normal_done_o),
    .ma_target_abort_o(ma_target_abort_o), .ma_rdata_o(ma_rdata_o),
    .secondary_reset_n_o(secondary_reset_n_o),
    .sec_logic_reset_n_o(sec_logic_reset_n_o),
    .sec_fast_b2b_o(sec_fast_b2b_o));
`default_nettype wire

//--- testbench/bct_queue_model.sv
// Far side: completion queues of both buses and the secondary SERR pin.
// Assumes the bench starts one completion per bus at a time.
`default_nettype none
module bct_queue_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bench commands; repeat delay zero means never repeat
    input wire logic [1:0] start_i,
    input wire logic [7:0] rep_dly_i,
    input wire logic serr_pull_i,
    // Toward the block
    input wire logic [1:0] discard_i,
    output logic [1:0] head_o,
    output logic [1:0] rep_o,
    output logic serr_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q [2];
    // Pull-up leaves the pin high when released
    assign serr_n_o = !serr_pull_i;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            head_o <= 2'h0;
            rep_o <= 2'h0;
            cnt_q[0] <= 8'h00;
            cnt_q[1] <= 8'h00;
        end else begin
            for (int b = 0; b < 2; b++) begin
                rep_o[b] <= 1'h0;
                cnt_q[b] <= cnt_q[b] + 8'h01;
                if (start_i[b]) begin
                    head_o[b] <= 1'h1;
                    cnt_q[b] <= 8'h00;
                end else if (discard_i[b] || rep_o[b]) begin
                    head_o[b] <= 1'h0;
                end else if (head_o[b] && rep_dly_i != 0 &&
                             cnt_q[b] == rep_dly_i) begin
                    rep_o[b] <= 1'h1;
                end
            end
        end
    end
endmodule : bct_queue_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for bct_top with the queue model on the far side.
// Assumes short timer parameters so a timeout takes tens of cycles.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LONG = 64;
    localparam int SHORT = 16;
    logic clk_i = 0, rstn_i = 0, wr_en = 0, rd_en = 0, cmd = 0, pull = 0;
    logic ma_ev = 0, ma_po = 0, ma_rd = 0, ack, nd, ta, srst_n, slrst_n;
    logic fb2b, serr_n, serr_o, oe;
    logic [7:0] addr = 8'h00, rep_dly = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, ma_rdata;
    logic [3:0] be_n = 4'hF;
    logic [1:0] start = 2'h0, head, rep, disc;
    int err_total = 0, n_compared = 0, oe_cnt = 0, disc_cnt = 0;
    always #12.5 clk_i = !clk_i;
    always @(posedge clk_i) begin
        oe_cnt <= oe_cnt + oe;
        disc_cnt <= disc_cnt + (disc != 0);
    end
    bct_top #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) dut (.clk_i(clk_i),
        .rstn_i(rstn_i), .cfg_wr_i(wr_en), .cfg_rd_i(rd_en),
        .cfg_addr_i(addr), .cfg_wdata_i(wdata),
        .primary_byte_enables_n_i(be_n), .cfg_rdata_o(rdata),
        .cfg_ack_o(ack), .cmd_system_error_forward_enable_i(cmd), .dc_head_i(head),
        .dc_repeat_i(rep), .dc_discard_o(disc), .ma_event_i(ma_ev),
        .ma_posted_i(ma_po), .ma_read_i(ma_rd), .ma_normal_done_o(nd),
        .ma_target_abort_o(ta), .ma_rdata_o(ma_rdata),
        .secondary_reset_n_o(srst_n), .sec_logic_reset_n_o(slrst_n),
        .sec_fast_b2b_o(fb2b), .secondary_system_error_in_n_i(serr_n),
        .primary_system_error_out_o(serr_o),
        .primary_system_error_out_oe_o(oe));
    bct_queue_model u_q (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start),
        .rep_dly_i(rep_dly), .serr_pull_i(pull), .discard_i(disc),
        .head_o(head), .rep_o(rep), .serr_n_o(serr_n));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                       logic [3:0] be, logic [31:0] exp);
        @(posedge clk_i);
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wdata <= d;
        be_n <= be;
        @(posedge clk_i);
        wr_en <= 0;
        rd_en <= 0;
        #1 chk("ack", ack, 1);
        if (!w) chk("read", rdata, exp);
    endtask : acc
    task automatic wr(logic [31:0] d, logic [3:0] be = 4'h0);
        acc(1, 8'h3C, d, be, 0);
    endtask : wr
    task automatic t_regs;
        acc(0, 8'h3C, 0, 4'h0, 32'h0);
        chk("srst idle", {srst_n, slrst_n, fb2b}, 3'h6);
        wr(32'hFFFF_FFFF);
        acc(0, 8'h3C, 0, 4'h0, 32'h0B6F_0000);
        chk("srst on", {srst_n, slrst_n}, 2'h0);
        wr(32'h0, 4'h7);
        acc(1, 8'h38, 0, 4'h0, 0);
        acc(0, 8'h3C, 0, 4'h0, 32'h006F_0000);
        acc(0, 8'h38, 0, 4'h0, 32'h0);
        wr(32'h0);
        @(posedge clk_i);
        #1 chk("srst off", {srst_n, slrst_n}, 2'h3);
    endtask : t_regs
    task automatic t_tmo(logic bus, logic sh, logic en, logic c);
        int t = 0;
        int n = sh ? SHORT : LONG;
        int o = oe_cnt;
        logic [31:0] v = {4'h0, en, 1'h0, sh & bus, sh & !bus, 24'h0};
        wr(v);
        cmd <= c;
        start[bus] <= 1;
        @(posedge clk_i);
        start <= 0;
        while (!disc[bus] && t < 3 * LONG) begin
            @(posedge clk_i);
            #1 t++;
        end
        chk("tmo len", t >= n && t <= n + 4, 1);
        repeat (2) @(posedge clk_i);
        chk("tmo serr", oe_cnt - o, en && c);
        acc(0, 8'h3C, 0, 4'h0, v | 32'h0400_0000);
        wr(v);
        acc(0, 8'h3C, 0, 4'h0, v | 32'h0400_0000);
        wr(v | 32'h0400_0000);
        acc(0, 8'h3C, 0, 4'h0, v);
    endtask : t_tmo
    task automatic t_nodisc(logic [31:0] v, logic [7:0] dly);
        int d = disc_cnt;
        wr(v);
        rep_dly <= dly;
        start[1] <= 1;
        @(posedge clk_i);
        start <= 0;
        repeat (2 * LONG) @(posedge clk_i);
        chk("no discard", disc_cnt - d, 0);
        acc(0, 8'h3C, 0, 4'h0, v);
    endtask : t_nodisc
    task automatic t_ma;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr({10'h0, m[0], 21'h0});
                cmd <= 1;
                ma_ev <= 1;
                ma_po <= k == 0;
                ma_rd <= k == 1;
                @(posedge clk_i);
                ma_ev <= 0;
                #1 chk("ma done", nd, !m && k);
                chk("ma abort", ta, m && k);
                chk("ma data", ma_rdata, (!m && k == 1) ? '1 : 0);
                chk("ma serr", oe, m && !k);
            end
        end
    endtask : t_ma
    task automatic t_fwd;
        for (int f = 0; f < 2; f++) begin
            wr({14'h0, f[0], 17'h0});
            pull <= 1;
            repeat (6) @(posedge clk_i);
            #1 chk("fwd", oe, f);
            chk("serr data", serr_o, 0);
            pull <= 0;
            repeat (6) @(posedge clk_i);
        end
    endtask : t_fwd
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1;
        t_regs;
        for (int i = 0; i < 4; i++) t_tmo(i[1], i[0], i != 0, i != 2);
        t_ma;
        t_fwd;
        t_nodisc(32'h0200_0000, 8'h05);
        t_nodisc(32'h0240_0000, 8'h00);
        test_done;
    end
    // Whole run needs about 570 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        test_done;
    end
endmodule : tb
`default_nettype wire
